// >>> pkg/snft_pkg.sv
// constants, encodings and types shared by the serial nand feature table
package snft_pkg;

    // ------------------------------------------------------------------
    // link commands
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_GET_FEATURE   = 8'h0F;
    localparam logic [7:0] CMD_SET_FEATURE   = 8'h1F;
    localparam logic [7:0] CMD_PROTECT_EXEC  = 8'h2A;
    localparam logic [7:0] CMD_RESET_A       = 8'hFF;
    localparam logic [7:0] CMD_RESET_B       = 8'hFE;

    // ------------------------------------------------------------------
    // feature addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_BLOCK_LOCK   = 8'hA0;
    localparam logic [7:0] ADDR_DEVICE_CFG   = 8'hB0;
    localparam logic [7:0] ADDR_OP_STATUS    = 8'hC0;
    localparam logic [7:0] ADDR_FLIP_THRESH  = 8'h10;
    localparam logic [7:0] ADDR_FLIP_COUNT   = 8'h20;
    localparam logic [7:0] ADDR_MAX_FLIP     = 8'h30;
    localparam logic [7:0] ADDR_FLIP_REP0    = 8'h40;
    localparam logic [7:0] ADDR_FLIP_REP1    = 8'h50;
    localparam logic [7:0] ADDR_FLIP_REP2    = 8'h60;
    localparam logic [7:0] ADDR_FLIP_REP3    = 8'h70;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LOCK_WD_BIT     = 7;
    localparam int LOCK_RANGE_LSB  = 3;
    localparam int CFG_PROTECT_BIT = 7;
    localparam int CFG_ID_READ_BIT = 6;
    localparam int CFG_ECC_BIT     = 4;
    localparam int CFG_BBI_BIT     = 2;
    localparam int CFG_FAST_BIT    = 1;
    localparam int THRESH_LSB      = 4;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic       RST_LOCK_WD     = 1'h0;
    localparam logic [2:0] LOCK_RANGE_NONE = 3'h0;
    localparam logic [2:0] LOCK_RANGE_ALL  = 3'h7;
    localparam logic [2:0] RST_LOCK_RANGE  = LOCK_RANGE_ALL;
    localparam logic       RST_PROTECT     = 1'h0;
    localparam logic       RST_ID_READ     = 1'h0;
    localparam logic       RST_ECC         = 1'h1;
    localparam logic       RST_FAST        = 1'h1;
    localparam logic       RST_WEL         = 1'h0;
    localparam logic       BBI_VALUE       = 1'h1;
    localparam logic [3:0] RST_THRESH      = 4'h0;
    localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA = 3'b010,
        ST_OUT  = 3'b011,
        ST_SKIP = 3'b100
    } snft_state_e;

endpackage

// >>> pkg/snft_link_if.sv
// byte-level carrier between the serial front end and the feature core
`timescale 1ns/10ps
interface snft_link_if;
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic       rx_first;
    logic       frame_end;
    logic [7:0] tx_data;

    modport serial (output rx_byte, output rx_valid, output rx_first, output frame_end, input tx_data);
    modport core   (input rx_byte, input rx_valid, input rx_first, input frame_end, output tx_data);
endinterface

// >>> design/snft_serial.sv
// serial front end: sampled sck/si to bytes, bytes to so
`timescale 1ns/10ps
module snft_serial
    import snft_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic si_i,
    output logic      so_o,
    output logic      so_oe_o,
    snft_link_if.serial link
);

    typedef struct packed {
        logic       sck_q;
        logic       cs_n_q;
        logic [2:0] bit_cnt;
        logic [7:0] rx_sr;
        logic       first;
        logic [7:0] tx_sr;
        logic       so;
        logic       so_oe;
        logic [7:0] rx_byte;
        logic       rx_valid;
        logic       rx_first;
        logic       frame_end;
    } snft_serial_s;

    snft_serial_s q;
    snft_serial_s next_q;
    logic         sck_rise;
    logic         sck_fall;

    // ------------------------------------------------------------------
    // bit engine
    // ------------------------------------------------------------------
    always_comb begin
        next_q           = q;
        next_q.rx_valid  = 1'b0;
        next_q.frame_end = 1'b0;
        next_q.sck_q     = sck_i;
        next_q.cs_n_q    = cs_n_i;
        sck_rise         = sck_i & ~q.sck_q;
        sck_fall         = ~sck_i & q.sck_q;
        if (cs_n_i) begin
            next_q.bit_cnt = 3'h0;
            next_q.first   = 1'b1;
            next_q.so      = 1'b0;
            next_q.so_oe   = 1'b0;
            next_q.frame_end = ~q.cs_n_q;
        end else begin
            next_q.so_oe = 1'b1;
            if (sck_rise) begin
                next_q.rx_sr   = {q.rx_sr[6:0], si_i};
                next_q.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == BITS_PER_BYTE_M1) begin
                    next_q.rx_byte  = {q.rx_sr[6:0], si_i};
                    next_q.rx_valid = 1'b1;
                    next_q.rx_first = q.first;
                    next_q.first    = 1'b0;
                end
            end
            // reload on every byte boundary so live status is re-read each byte
            if (sck_fall) begin
                if (q.bit_cnt == 3'h0) begin
                    next_q.so    = link.tx_data[7];
                    next_q.tx_sr = {link.tx_data[6:0], 1'b0};
                end else begin
                    next_q.so    = q.tx_sr[7];
                    next_q.tx_sr = {q.tx_sr[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{sck_q: 1'b0, cs_n_q: 1'b1, first: 1'b1, default: '0};
        end else begin
            q <= next_q;
        end
    end

    assign so_o           = q.so;
    assign so_oe_o        = q.so_oe;
    assign link.rx_byte   = q.rx_byte;
    assign link.rx_valid  = q.rx_valid;
    assign link.rx_first  = q.rx_first;
    assign link.frame_end = q.frame_end;

endmodule

// >>> design/snft_top.sv
// feature and status register bank behind the serial command link
`timescale 1ns/10ps

// Summary of operation
// - set-feature values survive soft reset commands; only power-on restores them.
// - set-feature never touches the write enable latch.
// - reserved feature bits always read as zero.
// - ecc related fields except the flip threshold report zero while internal ecc is disabled.
// - power-on reset loads every feature bit with its default.
// - write protect low with lock write disable set freezes lock fields.
// - three-bit lock range, none to all, defaults to all locked.
// - protect enable defaults zero; protect execute accepted only when set.
// - id read enable bit selects parameter page and unique id mode.
// - ecc enable bit switches internal ecc, default on.
// - bad block inhibit bit is read-only and reads one.
// - fast read enable bit selects high speed page read, default on.
// - get-feature repeats the selected byte until chip select rises.
// - write enable command sets the write enable latch.
// - status bit zero reads one while busy, zero when ready.
module snft_top
    import snft_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        wp_n_i,
    input  wire logic        op_in_progress_i,
    input  wire logic [1:0]  ecc_state_i,
    input  wire logic        program_fail_i,
    input  wire logic        erase_fail_i,
    input  wire logic [7:0]  flip_count_i,
    input  wire logic [3:0]  max_flip_i,
    input  wire logic [2:0]  max_flip_sector_i,
    input  wire logic [31:0] flip_report_i,
    output logic             so_o,
    output logic             so_oe_o,
    output logic             lock_reg_write_disable_o,
    output logic [2:0]       lock_range_o,
    output logic             protect_enable_o,
    output logic             id_read_enable_o,
    output logic             ecc_enable_o,
    output logic             fast_read_enable_o,
    output logic [3:0]       flip_threshold_o,
    output logic             write_enable_latch_o,
    output logic             protect_exec_o,
    output logic             soft_reset_o
);

    typedef struct packed {
        snft_state_e state;
        logic [7:0]  cmd;
        logic [7:0]  addr;
        logic        lock_wd;
        logic [2:0]  lock_range;
        logic        protect_en;
        logic        id_read_en;
        logic        ecc_en;
        logic        fast_en;
        logic        write_enable_latch;
        logic [3:0]  thresh;
        logic        protect_exec;
        logic        soft_reset;
    } snft_core_s;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------------
    snft_link_if link ();

    snft_serial u_serial (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_sync_n),
        .cs_n_i    (cs_n_i),
        .sck_i     (sck_i),
        .si_i      (si_i),
        .so_o      (so_o),
        .so_oe_o   (so_oe_o),
        .link      (link.serial)
    );

    snft_core_s q;
    snft_core_s next_q;
    logic       cmd_byte;
    logic       busy_allowed;
    logic       lock_frozen;

    // ------------------------------------------------------------------
    // feature read decode
    // ------------------------------------------------------------------
    function automatic logic [7:0] feature_read(input logic [7:0] addr, input snft_core_s c,
                                                input logic busy, input logic [1:0] eccs,
                                                input logic pfail, input logic efail,
                                                input logic [7:0] fcnt, input logic [3:0] mflip,
                                                input logic [2:0] msect, input logic [31:0] frep);
        logic [7:0] v;
        v = 8'h00;
        if (addr == ADDR_BLOCK_LOCK) begin
            v[LOCK_WD_BIT] = c.lock_wd;
            v[LOCK_RANGE_LSB +: 3] = c.lock_range;
        end else if (addr == ADDR_DEVICE_CFG) begin
            v[CFG_PROTECT_BIT] = c.protect_en;
            v[CFG_ID_READ_BIT] = c.id_read_en;
            v[CFG_ECC_BIT]     = c.ecc_en;
            v[CFG_BBI_BIT]     = BBI_VALUE;
            v[CFG_FAST_BIT]    = c.fast_en;
        end else if (addr == ADDR_OP_STATUS) begin
            v[5:4] = c.ecc_en ? eccs : 2'h0;
            v[3]   = pfail;
            v[2]   = efail;
            v[1]   = c.write_enable_latch;
            v[0]   = busy;
        end else if (addr == ADDR_FLIP_THRESH) begin
            v[THRESH_LSB +: 4] = c.thresh;
        end else if (!c.ecc_en) begin
            v = 8'h00;
        end else if (addr == ADDR_FLIP_COUNT) begin
            v = fcnt;
        end else if (addr == ADDR_MAX_FLIP) begin
            v = {mflip, 1'b0, msect};
        end else if (addr == ADDR_FLIP_REP0) begin
            v = frep[7:0];
        end else if (addr == ADDR_FLIP_REP1) begin
            v = frep[15:8];
        end else if (addr == ADDR_FLIP_REP2) begin
            v = frep[23:16];
        end else if (addr == ADDR_FLIP_REP3) begin
            v = frep[31:24];
        end else begin
            v = 8'h00;
        end
        return v;
    endfunction

    // status is sampled live so busy and fail bits track while the byte repeats
    assign link.tx_data = (q.state == ST_OUT) ?
        feature_read(q.addr, q, op_in_progress_i, ecc_state_i, program_fail_i, erase_fail_i,
                     flip_count_i, max_flip_i, max_flip_sector_i, flip_report_i) : 8'h00;

    assign cmd_byte     = link.rx_valid & link.rx_first & (q.state == ST_IDLE);
    // while busy only get-feature (any address) and the two reset commands are honoured
    assign busy_allowed = ~op_in_progress_i | (link.rx_byte == CMD_GET_FEATURE) |
                          (link.rx_byte == CMD_RESET_A) | (link.rx_byte == CMD_RESET_B);
    assign lock_frozen  = ~wp_n_i & q.lock_wd;

    // ------------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------------
    always_comb begin
        next_q              = q;
        next_q.protect_exec = 1'b0;
        next_q.soft_reset   = 1'b0;
        if (link.frame_end) begin
            next_q.state = ST_IDLE;
        end else if (link.rx_valid) begin
            case (q.state)
                ST_IDLE: begin
                    next_q.state = ST_SKIP;
                    next_q.cmd   = link.rx_byte;
                    if (cmd_byte && busy_allowed) begin
                        if ((link.rx_byte == CMD_GET_FEATURE) || (link.rx_byte == CMD_SET_FEATURE)) begin
                            next_q.state = ST_ADDR;
                        end else if (link.rx_byte == CMD_WRITE_ENABLE) begin
                            next_q.write_enable_latch = 1'b1;
                        end else if (link.rx_byte == CMD_WRITE_DISABLE) begin
                            next_q.write_enable_latch = 1'b0;
                        end else if (link.rx_byte == CMD_PROTECT_EXEC) begin
                            next_q.protect_exec = q.protect_en & q.write_enable_latch;
                        end else if ((link.rx_byte == CMD_RESET_A) || (link.rx_byte == CMD_RESET_B)) begin
                            next_q.soft_reset = 1'b1;
                        end
                    end
                end
                ST_ADDR: begin
                    next_q.addr  = link.rx_byte;
                    next_q.state = (q.cmd == CMD_GET_FEATURE) ? ST_OUT : ST_DATA;
                end
                ST_DATA: begin
                    next_q.state = ST_SKIP;
                    if (q.addr == ADDR_BLOCK_LOCK) begin
                        if (!lock_frozen) begin
                            next_q.lock_wd    = link.rx_byte[LOCK_WD_BIT];
                            next_q.lock_range = link.rx_byte[LOCK_RANGE_LSB +: 3];
                        end
                    end else if (q.addr == ADDR_DEVICE_CFG) begin
                        next_q.protect_en = link.rx_byte[CFG_PROTECT_BIT];
                        next_q.id_read_en = link.rx_byte[CFG_ID_READ_BIT];
                        next_q.ecc_en     = link.rx_byte[CFG_ECC_BIT];
                        next_q.fast_en    = link.rx_byte[CFG_FAST_BIT];
                    end else if (q.addr == ADDR_FLIP_THRESH) begin
                        next_q.thresh = link.rx_byte[THRESH_LSB +: 4];
                    end
                    // status, count and report addresses are read-only: write dropped
                end
                ST_OUT: begin
                    next_q.state = ST_OUT;
                end
                default: begin
                    next_q.state = ST_SKIP;
                end
            endcase
        end
    end

    // only the power-on reset reaches these flops; soft reset is a pulse out
    always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q <= '{state: ST_IDLE, cmd: 8'h00, addr: 8'h00, lock_wd: RST_LOCK_WD,
                   lock_range: RST_LOCK_RANGE, protect_en: RST_PROTECT, id_read_en: RST_ID_READ,
                   ecc_en: RST_ECC, fast_en: RST_FAST, write_enable_latch: RST_WEL, thresh: RST_THRESH,
                   protect_exec: 1'b0, soft_reset: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign lock_reg_write_disable_o = q.lock_wd;
    assign lock_range_o             = q.lock_range;
    assign protect_enable_o         = q.protect_en;
    assign id_read_enable_o         = q.id_read_en;
    assign ecc_enable_o             = q.ecc_en;
    assign fast_read_enable_o       = q.fast_en;
    assign flip_threshold_o         = q.thresh;
    assign write_enable_latch_o     = q.write_enable_latch;
    assign protect_exec_o           = q.protect_exec;
    assign soft_reset_o             = q.soft_reset;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_sync_n);

    property p_wel_rise;
        $rose(q.write_enable_latch) |-> $past(cmd_byte) && ($past(link.rx_byte) == CMD_WRITE_ENABLE);
    endproperty
    a_wel_rise: assert property (p_wel_rise) else $error("latch set without write enable");

    property p_wel_set;
        cmd_byte && !op_in_progress_i && (link.rx_byte == CMD_WRITE_ENABLE) && !link.frame_end |=> q.write_enable_latch;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("write enable did not set latch");

    property p_lock_frozen;
        (q.state == ST_DATA) && link.rx_valid && (q.addr == ADDR_BLOCK_LOCK) && lock_frozen
            && !link.frame_end |=> $stable(q.lock_range) && $stable(q.lock_wd);
    endproperty
    a_lock_frozen: assert property (p_lock_frozen) else $error("locked field changed");

    property p_reserved_lock;
        (q.state == ST_OUT) && (q.addr == ADDR_BLOCK_LOCK)
            |-> (link.tx_data[6] == 1'b0) && (link.tx_data[2:0] == 3'h0);
    endproperty
    a_reserved_lock: assert property (p_reserved_lock) else $error("reserved bit nonzero");

    property p_bbi;
        (q.state == ST_OUT) && (q.addr == ADDR_DEVICE_CFG) |-> link.tx_data[CFG_BBI_BIT] && !link.tx_data[0];
    endproperty
    a_bbi: assert property (p_bbi) else $error("bad block inhibit bit wrong");

    property p_ecc_gate;
        (q.state == ST_OUT) && !q.ecc_en && (q.addr == ADDR_FLIP_COUNT) |-> link.tx_data == 8'h00;
    endproperty
    a_ecc_gate: assert property (p_ecc_gate) else $error("flip count shown with ecc off");

    property p_busy_bit;
        (q.state == ST_OUT) && (q.addr == ADDR_OP_STATUS) |-> link.tx_data[0] == op_in_progress_i;
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit mismatch");

    property p_protect;
        protect_exec_o |-> $past(q.protect_en) && $past(q.write_enable_latch);
    endproperty
    a_protect: assert property (p_protect) else $error("protect accepted while disabled");

    property p_soft_reset_keeps;
        soft_reset_o |-> $stable(q.ecc_en) && $stable(q.lock_range) && $stable(q.thresh) && $stable(q.fast_en);
    endproperty
    a_soft_reset_keeps: assert property (p_soft_reset_keeps) else $error("soft reset altered feature");

    property p_repeat;
        (q.state == ST_OUT) && !link.frame_end |=> q.state == ST_OUT;
    endproperty
    a_repeat: assert property (p_repeat) else $error("output stopped before deselect");

endmodule

// >>> testbench/snft_host.sv
// host model of the serial command link: framed command, address and data bytes
`timescale 1ns/10ps
module snft_host
    import snft_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o
);
    // sck half period in system clocks; the front end needs two per level at least
    localparam int HALF = 4;

    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // mode 0, msb first: si set while sck is low, so taken at the rise
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            tick(HALF);
            sck_o = 1'b1;
            rx[i] = so_i;
            tick(HALF);
            sck_o = 1'b0;
        end
    endtask

    // the bench only hands in mapped feature addresses
    task automatic frame(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] dat,
                         output logic [7:0] r0, output logic [7:0] r1);
        logic [7:0] junk;
        r0 = 8'h00;
        r1 = 8'h00;
        cs_n_o = 1'b0;
        tick(2);
        xbyte(cmd, junk);
        if (cmd == CMD_GET_FEATURE || cmd == CMD_SET_FEATURE) xbyte(adr, junk);
        if (cmd == CMD_SET_FEATURE) xbyte(dat, junk);
        if (cmd == CMD_GET_FEATURE) begin
            xbyte(dat, r0);
            xbyte(~dat, r1);
        end
        tick(2);
        cs_n_o = 1'b1;
        // released data line must not keep showing the last bit
        si_o = ~si_o;
        tick(4);
    endtask
endmodule

// >>> testbench/tb_serial_nand_feature_table.sv
// self-checking bench for the serial nand feature register bank
`timescale 1ns/10ps
module tb_serial_nand_feature_table
    import snft_pkg::*;
;
    logic        clk, rst_n, cs_n, sck, si, wp_n, busy, pfail, efail, so, so_oe;
    logic        lock_wd, prot, idr, ecc, fast, write_enable_latch, pexec, srst;
    logic [1:0]  ecc_st;
    logic [2:0]  msect, lrange;
    logic [3:0]  mflip, thr;
    logic [7:0]  fcnt, r0, r1;
    logic [31:0] frep;
    int          fails, num_checks, n_srst, n_pexec, n_oe;

    initial clk = 1'b0;
    always #4 clk = ~clk;

    snft_top uut (.clk_sys_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .wp_n_i(wp_n), .op_in_progress_i(busy), .ecc_state_i(ecc_st), .program_fail_i(pfail),
        .erase_fail_i(efail), .flip_count_i(fcnt), .max_flip_i(mflip), .max_flip_sector_i(msect),
        .flip_report_i(frep), .so_o(so), .so_oe_o(so_oe), .lock_reg_write_disable_o(lock_wd),
        .lock_range_o(lrange), .protect_enable_o(prot), .id_read_enable_o(idr),
        .ecc_enable_o(ecc), .fast_read_enable_o(fast), .flip_threshold_o(thr),
        .write_enable_latch_o(write_enable_latch), .protect_exec_o(pexec), .soft_reset_o(srst));

    snft_host host (.clk_i(clk), .so_i(so), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

    // sampled mid-cycle so a one-cycle pulse is counted exactly once
    always @(negedge clk) begin
        if (srst === 1'b1) n_srst++;
        if (pexec === 1'b1) n_pexec++;
        if (so_oe === 1'b1) n_oe++;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a get repeats its byte, so both returned bytes must match
    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        host.frame(CMD_GET_FEATURE, adr, 8'h00, r0, r1);
        chk(r0, exp);
        chk(r1, exp);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        host.frame(CMD_SET_FEATURE, adr, dat, r0, r1);
    endtask

    task automatic cmd(input logic [7:0] c);
        host.frame(c, 8'h00, 8'h00, r0, r1);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        give_verdict();
    end

    initial begin
        {rst_n, busy, pfail, efail, ecc_st} = '0;
        wp_n = 1'b1;
        fcnt = 8'hA5;
        mflip = 4'h9;
        msect = 3'h5;
        frep = 32'hC35A_96E1;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        chk({lock_wd, lrange, prot, idr, ecc, fast}, 8'h73);
        chk({3'h0, write_enable_latch, thr}, 8'h00);
        rd(ADDR_BLOCK_LOCK, 8'h38);
        rd(ADDR_DEVICE_CFG, 8'h16);
        wr(ADDR_DEVICE_CFG, 8'hFF);
        rd(ADDR_DEVICE_CFG, 8'hD6);
        chk({4'h0, prot, idr, ecc, fast}, 8'h0F);
        // a one-byte frame keeps the output enabled for all 68 clocks of select
        n_oe = 0;
        cmd(CMD_WRITE_ENABLE);
        chk({7'h0, write_enable_latch}, 8'h01);
        chk(n_oe[7:0], 8'h44);
        wr(ADDR_OP_STATUS, 8'h00);
        rd(ADDR_OP_STATUS, 8'h02);
        cmd(CMD_PROTECT_EXEC);
        chk(n_pexec[7:0], 8'h01);
        cmd(CMD_RESET_A);
        cmd(CMD_RESET_B);
        chk(n_srst[7:0], 8'h02);
        rd(ADDR_DEVICE_CFG, 8'hD6);
        // busy device ignores write disable but still answers status
        {busy, pfail, efail, ecc_st} = 5'h1F;
        cmd(CMD_WRITE_DISABLE);
        rd(ADDR_OP_STATUS, 8'h3F);
        busy = 1'b0;
        cmd(CMD_WRITE_DISABLE);
        rd(ADDR_OP_STATUS, 8'h3C);
        rd(ADDR_FLIP_COUNT, 8'hA5);
        rd(ADDR_MAX_FLIP, 8'h95);
        rd(ADDR_FLIP_REP0, 8'hE1);
        rd(ADDR_FLIP_REP3, 8'hC3);
        wr(ADDR_DEVICE_CFG, 8'h00);
        chk({7'h0, ecc}, 8'h00);
        // protect enable and latch both clear now, so execute must be refused
        cmd(CMD_PROTECT_EXEC);
        chk(n_pexec[7:0], 8'h01);
        rd(ADDR_FLIP_COUNT, 8'h00);
        rd(ADDR_OP_STATUS, 8'h0C);
        wr(ADDR_FLIP_THRESH, 8'hFF);
        rd(ADDR_FLIP_THRESH, 8'hF0);
        chk({4'h0, thr}, 8'h0F);
        wr(ADDR_BLOCK_LOCK, 8'hFF);
        rd(ADDR_BLOCK_LOCK, 8'hB8);
        wp_n = 1'b0;
        wr(ADDR_BLOCK_LOCK, 8'h00);
        rd(ADDR_BLOCK_LOCK, 8'hB8);
        wp_n = 1'b1;
        wr(ADDR_BLOCK_LOCK, 8'h00);
        chk({lock_wd, 4'h0, lrange}, 8'h00);
        give_verdict();
    end
endmodule
